// [shared/lsal_defines.vh]
// constants for the limit status and alert logic
// How it works
// - out-of-limit comparison sets channel status bit
// - status bits stay set until read
// - read clears only bits whose condition ended
// - first register bit 7 summarises second register
// - first register bits 6..0 map temperature, voltage channels
// - bit 0 shows thermal alarm when pin reassigned
// - second register bits 7,6 flag diode faults
// - bit 5 follows shared pin function
// - second register bits 4..2 flag slow fans
// - overheat bit follows condition, not sticky
// - bit 0 flags 12 V or VID change
// - alert held while unmasked fault or unread
// - masks gate alert only, never status
// - first mask bit 7 blocks second register
// - first mask bits 6..0 gate matching status
// - alert routable to either of two pins
// - high is greater-than, low is less-or-equal
// - alert disabled until a pin carries it
// - second mask bits gate matching second status
`ifndef LSAL_DEFINES_VH
`define LSAL_DEFINES_VH

// register map
`define LSAL_ADDR_PRI_FLAGS  8'h41
`define LSAL_ADDR_SEC_FLAGS  8'h42
`define LSAL_ADDR_PRI_MASK   8'h74
`define LSAL_ADDR_SEC_MASK   8'h75

// reset values
`define LSAL_FLAGS_RST       8'h00
`define LSAL_MASK_RST        8'h00

// field positions, first register
`define LSAL_PRI_SUMMARY     7
`define LSAL_PRI_LOW_CH      0

// field positions, second register
`define LSAL_SEC_DIODE_B     7
`define LSAL_SEC_DIODE_A     6
`define LSAL_SEC_SHARED      5
`define LSAL_SEC_THIRD_COOLER_SLOW        4
`define LSAL_SEC_FIRST_COOLER_SLOW        2
`define LSAL_SEC_OVERHEAT    1
`define LSAL_SEC_TWELVE      0

// comparator channel indices
`define LSAL_CH_TWELVE       7
`define LSAL_NUM_CH          8

// shared pin function codes
`define LSAL_P14_TACH        2'h0
`define LSAL_P14_HEAT        2'h1
`define LSAL_P14_ALERT       2'h2
`define LSAL_P14_GPIO        2'h3

`endif

// [core/lsal_sync2.v]
// two-flop synchroniser for pin inputs
`default_nettype none

module lsal_sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout_r
);

    reg [W-1:0] meta_r; // first stage, read only by dout_r

    // plain double flop; nothing else taps the first stage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= {W{1'b0}};
            dout_r <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout_r <= meta_r;
        end
    end

endmodule

`default_nettype wire

// [core/lsal_limit_cmp.v]
// window comparator holding the latest limit result per channel
`default_nettype none

module lsal_limit_cmp #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire         cmp_valid,
    input  wire [W-1:0] cmp_value,
    input  wire [W-1:0] cmp_low,
    input  wire [W-1:0] cmp_high,
    output reg          out_of_limit_r
);

    wire high_hit; // strictly above high limit
    wire low_hit;  // at or below low limit

    assign high_hit = (cmp_value > cmp_high);
    assign low_hit  = (cmp_value <= cmp_low);

    // result only changes when a new conversion lands
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_of_limit_r <= 1'b0;
        end else if (cmp_valid) begin
            out_of_limit_r <= high_hit | low_hit;
        end
    end

endmodule

`default_nettype wire

// [core/lsal_alert_core.v]
// limit status registers, alert masks and alert pin drive
`include "lsal_defines.vh"
`default_nettype none

module lsal_alert_core #(
    parameter DW  = 8,                 // reading width
    parameter NCH = `LSAL_NUM_CH       // analog channels
) (
    input  wire              clk,
    input  wire              sys_rst,
    // register port from the serial interface engine
    input  wire [7:0]        reg_addr,
    input  wire              reg_wr,
    input  wire              reg_rd,
    input  wire [7:0]        reg_wdata,
    output reg  [7:0]        reg_rdata_r,
    // conversion results, channel 0 is 2.5 V, channel 7 is 12 V
    input  wire [NCH-1:0]    meas_valid,
    input  wire [NCH*DW-1:0] meas_value,
    input  wire [NCH*DW-1:0] meas_low_limit,
    input  wire [NCH*DW-1:0] meas_high_limit,
    // fault levels from same-clock logic
    input  wire              remote_diode_a_fault,
    input  wire              remote_diode_b_fault,
    input  wire              first_cooler_slow,
    input  wire              second_cooler_slow,
    input  wire              third_cooler_slow,
    input  wire              fourth_cooler_slow,
    input  wire              heat_timer_over,
    input  wire              overheat_limit_flag,
    // asynchronous pins
    input  wire              heat_alarm_pin_n,
    input  wire              general_io_six,
    input  wire [4:0]        voltage_id_inputs,
    // configuration levels
    input  wire              heat_on_low_pin,
    input  wire              vid_change_sel,
    input  wire              alert_on_pin10,
    input  wire [1:0]        pin14_func,
    // open-drain alert pins
    output reg               alert_pin10_out_r,
    output reg               alert_pin10_oe_r,
    output reg               alert_pin14_out_r,
    output reg               alert_pin14_oe_r
);

    // synchronised pin levels; the alarm is inverted ahead of the
    // flops so that their reset value matches an idle pin
    wire       heat_alarm_s;      // thermal alarm asserted, active high
    wire       gpio_s;            // general input six
    wire [4:0] vid_s;             // voltage id code

    // per channel held comparison result
    wire [NCH-1:0] cmp_flag;

    // raw conditions feeding the status bits
    reg  [7:0] pri_cond;
    reg  [7:0] sec_cond;

    // storage
    reg  [7:0] pri_flags_r;       // first status register, bits 6..0 stored
    reg  [7:0] sec_flags_r;       // second status register
    reg  [7:0] pri_mask_r;        // first mask register
    reg  [7:0] sec_mask_r;        // second mask register
    reg  [4:0] vid_prev_r;        // last seen voltage id code
    reg  [2:0] vid_seen_r;        // settle shift, all ones once codes are real

    reg  [7:0] pri_flags_nxt;
    reg  [7:0] sec_flags_nxt;
    reg  [7:0] reg_rdata_nxt;

    wire       pri_rd;            // read strobe on first status
    wire       sec_rd;            // read strobe on second status
    wire       vid_changed;       // code moved since last sample
    wire [7:0] pri_view;          // first register as software sees it
    wire       pri_alert;         // unmasked bit of the first register
    wire       sec_alert;         // unmasked bit of the second register
    wire       alert_req;         // any unmasked status bit
    wire       alert_en;          // some pin carries the alert
    wire       pin14_alert;       // shared pin set to alert

    // comparator loop index
    genvar g;

    // pins cross into the clock domain before use
    lsal_sync2 #(
        .W (7)
    ) u_pin_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({~heat_alarm_pin_n, general_io_six, voltage_id_inputs}),
        .dout_r  ({heat_alarm_s, gpio_s, vid_s})
    );

    // one window comparator per analog channel
    // each comparator keeps its last verdict until the next conversion
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_cmp
            lsal_limit_cmp #(
                .W (DW)
            ) u_cmp (
                .clk            (clk),
                .sys_rst        (sys_rst),
                .cmp_valid      (meas_valid[g]),
                .cmp_value      (meas_value[g*DW +: DW]),
                .cmp_low        (meas_low_limit[g*DW +: DW]),
                .cmp_high       (meas_high_limit[g*DW +: DW]),
                .out_of_limit_r (cmp_flag[g])
            );
        end
    endgenerate

    // voltage id change tracking; the synchroniser still shows its reset
    // value for two edges after release and the previous code lags one
    // more, so comparisons wait until three edges have passed; otherwise
    // any non-zero code on the pins would look like a change
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vid_prev_r <= 5'h00;
            vid_seen_r <= 3'h0;
        end else begin
            vid_prev_r <= vid_s;
            vid_seen_r <= {vid_seen_r[1:0], 1'b1};
        end
    end

    // a change is a one-cycle pulse; the status bit makes it sticky
    assign vid_changed = vid_seen_r[2] & (vid_s != vid_prev_r);

    // conditions of the first status register
    // channel 7 is the 12 V input and belongs to the second register
    always @* begin
        pri_cond = `LSAL_FLAGS_RST;
        pri_cond[6:1] = cmp_flag[6:1];
        // low pin may be the thermal alarm input instead of 2.5 V
        if (heat_on_low_pin) begin
            pri_cond[`LSAL_PRI_LOW_CH] = heat_alarm_s;
        end else begin
            pri_cond[`LSAL_PRI_LOW_CH] = cmp_flag[0];
        end
    end

    // conditions of the second status register; these are levels from
    // same-clock logic, so they need no synchroniser of their own
    always @* begin
        sec_cond = `LSAL_FLAGS_RST;
        sec_cond[`LSAL_SEC_DIODE_B] = remote_diode_b_fault;
        sec_cond[`LSAL_SEC_DIODE_A] = remote_diode_a_fault;
        sec_cond[`LSAL_SEC_THIRD_COOLER_SLOW:`LSAL_SEC_FIRST_COOLER_SLOW] =
            {third_cooler_slow, second_cooler_slow, first_cooler_slow};
        sec_cond[`LSAL_SEC_OVERHEAT] = overheat_limit_flag;
        // shared pin function picks the bit 5 source
        case (pin14_func)
            `LSAL_P14_TACH: begin
                sec_cond[`LSAL_SEC_SHARED] = fourth_cooler_slow;
            end
            `LSAL_P14_HEAT: begin
                sec_cond[`LSAL_SEC_SHARED] = heat_timer_over;
            end
            `LSAL_P14_GPIO: begin
                sec_cond[`LSAL_SEC_SHARED] = gpio_s;
            end
            default: begin
                // pin carries the alert, nothing to report
                sec_cond[`LSAL_SEC_SHARED] = 1'b0;
            end
        endcase
        // 12 V window or voltage id change
        if (vid_change_sel) begin
            sec_cond[`LSAL_SEC_TWELVE] = vid_changed;
        end else begin
            sec_cond[`LSAL_SEC_TWELVE] = cmp_flag[`LSAL_CH_TWELVE];
        end
    end

    // read strobes on the two status addresses; the serial engine raises
    // reg_rd once per read, so a bit is cleared at most once per access
    assign pri_rd = reg_rd & (reg_addr == `LSAL_ADDR_PRI_FLAGS);
    assign sec_rd = reg_rd & (reg_addr == `LSAL_ADDR_SEC_FLAGS);

    // sticky update: a live condition always wins over a read clear,
    // so a bit whose fault persists survives the read
    // a fault that appears in the very cycle of the read is kept too
    always @* begin
        pri_flags_nxt = pri_cond | (pri_flags_r & {8{~pri_rd}});
        pri_flags_nxt[`LSAL_PRI_SUMMARY] = 1'b0; // summary is derived
        sec_flags_nxt = sec_cond | (sec_flags_r & {8{~sec_rd}});
        // overheat bit tracks its condition directly
        sec_flags_nxt[`LSAL_SEC_OVERHEAT] = overheat_limit_flag;
    end

    // status storage
    // reset clears every flag; nothing is reported until the first
    // conversions and fault levels arrive
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pri_flags_r <= `LSAL_FLAGS_RST;
            sec_flags_r <= `LSAL_FLAGS_RST;
        end else begin
            pri_flags_r <= pri_flags_nxt;
            sec_flags_r <= sec_flags_nxt;
        end
    end

    // mask registers, plain read/write; they never touch status
    // writes to the status addresses fall through and are ignored
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pri_mask_r <= `LSAL_MASK_RST;
            sec_mask_r <= `LSAL_MASK_RST;
        end else if (reg_wr) begin
            if (reg_addr == `LSAL_ADDR_PRI_MASK) begin
                pri_mask_r <= reg_wdata;
            end
            if (reg_addr == `LSAL_ADDR_SEC_MASK) begin
                sec_mask_r <= reg_wdata;
            end
        end
    end

    // summary bit set whenever the second register holds anything
    // it follows the stored flags, so it drops in the same cycle as the
    // last stored second-register bit clears, one cycle after the clearing read
    assign pri_view = {(|sec_flags_r), pri_flags_r[6:0]};

    // read data, registered; unmapped addresses read zero
    // the first register is read through its view so bit 7 is current
    always @* begin
        case (reg_addr)
            `LSAL_ADDR_PRI_FLAGS: begin
                reg_rdata_nxt = pri_view;
            end
            `LSAL_ADDR_SEC_FLAGS: begin
                reg_rdata_nxt = sec_flags_r;
            end
            `LSAL_ADDR_PRI_MASK: begin
                reg_rdata_nxt = pri_mask_r;
            end
            `LSAL_ADDR_SEC_MASK: begin
                reg_rdata_nxt = sec_mask_r;
            end
            default: begin
                reg_rdata_nxt = `LSAL_FLAGS_RST;
            end
        endcase
    end

    // capture read data only on a read so the bus sees a stable value
    // holding it between reads lets a slow serial engine shift it out
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= `LSAL_FLAGS_RST;
        end else if (reg_rd) begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // first register: each mask bit gates the status bit beside it;
    // bit 7 is left out because the summary is only a copy of the
    // second register and is gated there instead
    assign pri_alert = |(pri_flags_r[6:0] & ~pri_mask_r[6:0]);

    // second register: own mask per bit, and mask bit 7 of the first
    // register silences the whole register at once
    assign sec_alert = (|(sec_flags_r & ~sec_mask_r)) &
                       ~pri_mask_r[`LSAL_PRI_SUMMARY];

    // alert request: sticky bits already hold live faults, so the
    // alert covers both the fault period and the time until read;
    // masking never touches the flags themselves
    assign alert_req = pri_alert | sec_alert;

    // the alert function is on when any pin carries it; reset does not touch
    // the routing inputs, so a pin routed before reset still carries it after
    assign pin14_alert = (pin14_func == `LSAL_P14_ALERT);
    assign alert_en    = alert_on_pin10 | pin14_alert;

    // open-drain drive on pin 10: data always low, the enable pulls the
    // wire; registered so that the pin never glitches on a read clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alert_pin10_out_r <= 1'b0;
            alert_pin10_oe_r  <= 1'b0;
        end else begin
            // released unless this pin was chosen to carry the alert
            alert_pin10_out_r <= 1'b0;
            alert_pin10_oe_r  <= alert_en & alert_on_pin10 & alert_req;
        end
    end

    // open-drain drive on pin 14, same scheme; both pins may carry the
    // alert at once when both are routed, which suits a wired-or bus
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alert_pin14_out_r <= 1'b0;
            alert_pin14_oe_r  <= 1'b0;
        end else begin
            // released unless the shared pin is set to the alert function
            alert_pin14_out_r <= 1'b0;
            alert_pin14_oe_r  <= alert_en & pin14_alert & alert_req;
        end
    end

endmodule

`default_nettype wire

// [verification/lsal_alert_core_properties.sv]
// checker on the alert core ports
`include "lsal_defines.vh"
`default_nettype none
module lsal_alert_props (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       remote_diode_a_fault,
    input wire logic       remote_diode_b_fault,
    input wire logic       overheat_limit_flag,
    input wire logic       alert_on_pin10,
    input wire logic [1:0] pin14_func,
    input wire logic       alert_pin10_out_r,
    input wire logic       alert_pin10_oe_r,
    input wire logic       alert_pin14_out_r,
    input wire logic       alert_pin14_oe_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] m1_r;  // mirror of first mask
    logic [7:0] m2_r;  // mirror of second mask
    logic [2:0] q_r;   // quiet cycles, no access and no overheat
    wire rd41 = reg_rd && reg_addr == `LSAL_ADDR_PRI_FLAGS;
    wire rd42 = reg_rd && reg_addr == `LSAL_ADDR_SEC_FLAGS;
    wire rdx = reg_rd && reg_addr != 8'h41 && reg_addr != 8'h42 && reg_addr != 8'h74
        && reg_addr != 8'h75;
    // masks mirrored from writes, so the checker knows what is gated
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            m1_r <= 8'h00;
            m2_r <= 8'h00;
            q_r <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `LSAL_ADDR_PRI_MASK) m1_r <= reg_wdata;
            if (reg_wr && reg_addr == `LSAL_ADDR_SEC_MASK) m2_r <= reg_wdata;
            // only an access or a live overheat may release the alert
            q_r <= (reg_rd || reg_wr || overheat_limit_flag) ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
        end
    end
    // fault seen, then four quiet cycles before the read
    sequence s_a_pulse;
        remote_diode_a_fault ##1 !reg_rd [*4];
    endsequence
    a_out_zero:
    assert property (!alert_pin10_out_r && !alert_pin14_out_r) else $error("alert data not low");
    a_pin10_off:
    assert property (!alert_on_pin10 [*2] |-> !alert_pin10_oe_r) else $error("pin 10 unrouted");
    a_pin14_off:
    assert property ((pin14_func != `LSAL_P14_ALERT) [*2] |-> !alert_pin14_oe_r)
        else $error("pin 14 unrouted");
    a_raise_b:
    assert property ($rose(remote_diode_b_fault) && alert_on_pin10 && !m1_r[7] && !m2_r[7]
        |-> ##[1:3] alert_pin10_oe_r) else $error("alert not raised");
    a_sticky_a:
    assert property (s_a_pulse ##1 rd42 |=> reg_rdata_r[6]) else $error("diode flag lost");
    a_summary_bit:
    assert property (remote_diode_a_fault [*2] ##0 rd41 |=> reg_rdata_r[7])
        else $error("summary bit clear");
    a_overheat_live:
    assert property (!overheat_limit_flag [*3] ##0 rd42 |=> !reg_rdata_r[1])
        else $error("overheat flag stuck");
    a_unmapped_zero:
    assert property (rdx |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
    a_alert_hold:
    assert property ($fell(alert_pin10_oe_r) && alert_on_pin10 && $past(alert_on_pin10)
        |-> q_r < 3'h4) else $error("alert dropped unread");
endmodule
bind lsal_alert_core lsal_alert_props u_props (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata_r, .remote_diode_a_fault, .remote_diode_b_fault,
    .overheat_limit_flag, .alert_on_pin10, .pin14_func, .alert_pin10_out_r,
    .alert_pin10_oe_r, .alert_pin14_out_r, .alert_pin14_oe_r);
`default_nettype wire

// [verification/lsal_host_model.sv]
// host stand-in: register accesses and the pulled-up alert wire
`default_nettype none
module lsal_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata_r,
    input  wire logic       oe10,
    input  wire logic       oe14,
    output var logic [7:0]  reg_addr,
    output var logic        reg_wr,
    output var logic        reg_rd,
    output var logic [7:0]  reg_wdata,
    output wire logic       alert_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // pulled-up wire, low while either pin drives
    assign alert_n = !(oe10 || oe14);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // released address and data are inverted, never left looking valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // data taken an edge after the strobe, when it is settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata_r;
    endtask
endmodule
`default_nettype wire

// [verification/lsal_alert_core_bench.sv]
// self-checking bench for the alert core
`default_nettype none
module lsal_alert_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  lv = 8'h00;         // fault levels, bit = status bit
    logic [7:0]  mv = 8'h00;         // conversion pulses
    logic [63:0] val = {8{8'h80}};   // readings, in limits
    logic        heat_n = 1'b1;      // thermal pin idle high
    logic        gpio = 1'b0;
    logic        tmr = 1'b0;
    logic [4:0]  vid = 5'h00;
    logic        heat_sel = 1'b0;
    logic        vid_sel = 1'b0;
    logic        on10 = 1'b0;
    logic [1:0]  p14 = 2'h0;
    logic [7:0]  addr, wdat, rdat, got;
    logic        wr, rd, oe10, oe14, alert_n;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    always #2 clk = ~clk;
    lsal_alert_core dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(wr),
        .reg_rd(rd), .reg_wdata(wdat), .reg_rdata_r(rdat), .meas_valid(mv),
        .meas_value(val), .meas_low_limit({8{8'h10}}), .meas_high_limit({8{8'hC0}}),
        .remote_diode_a_fault(lv[6]), .remote_diode_b_fault(lv[7]),
        .first_cooler_slow(lv[2]), .second_cooler_slow(lv[3]), .third_cooler_slow(lv[4]),
        .fourth_cooler_slow(lv[5]), .heat_timer_over(tmr), .overheat_limit_flag(lv[1]),
        .heat_alarm_pin_n(heat_n), .general_io_six(gpio), .voltage_id_inputs(vid),
        .heat_on_low_pin(heat_sel), .vid_change_sel(vid_sel), .alert_on_pin10(on10),
        .pin14_func(p14), .alert_pin10_out_r(), .alert_pin10_oe_r(oe10),
        .alert_pin14_out_r(), .alert_pin14_oe_r(oe14));
    lsal_host_model host (.clk(clk), .reg_rdata_r(rdat), .oe10(oe10), .oe14(oe14),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdat), .alert_n(alert_n));
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, got);
        chk($sformatf("reg %h", a), exp, got);
    endtask
    task automatic al(input logic exp);
        chk("alert wire", {7'h0, exp}, {7'h0, alert_n});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one conversion result on one channel
    task automatic conv(input int c, input logic [7:0] v);
        @(posedge clk);
        val[c*8+:8] <= v;
        mv[c] <= 1'b1;
        @(posedge clk);
        mv[c] <= 1'b0;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        logic [7:0] a;
        logic [7:0] e;
        step(6);
        sys_rst <= 1'b0;
        rc(8'h41, 8'h00);
        rc(8'h42, 8'h00);
        rc(8'h43, 8'h00);
        host.wr(8'h74, 8'hA5);
        host.wr(8'h75, 8'h5A);
        host.wr(8'h41, 8'hFF);
        rc(8'h74, 8'hA5);
        rc(8'h75, 8'h5A);
        rc(8'h41, 8'h00);
        host.wr(8'h74, 8'h00);
        host.wr(8'h75, 8'h00);
        $display("test registers done");
        // every analog channel, both limit edges
        for (int c = 0; c < 8; c++) begin
            a = c < 7 ? 8'h41 : 8'h42;
            e = c < 7 ? 8'h01 << c : 8'h01;
            conv(c, 8'hC0);
            rc(a, 8'h00);
            conv(c, 8'h10);
            conv(c, 8'h80);
            rc(a, e);
            rc(a, 8'h00);
            conv(c, 8'hC1);
            rc(a, e);
            rc(a, e);
            conv(c, 8'h11);
            rc(a, e);
            rc(a, 8'h00);
        end
        heat_sel <= 1'b1;
        heat_n <= 1'b0;
        step(5);
        rc(8'h41, 8'h01);
        heat_n <= 1'b1;
        vid_sel <= 1'b1;
        vid <= 5'h15;
        step(5);
        host.rd(8'h41, got);
        rc(8'h41, 8'h80);
        rc(8'h42, 8'h01);
        rc(8'h42, 8'h00);
        heat_sel <= 1'b0;
        vid_sel <= 1'b0;
        $display("test limits done");
        // each same-clock fault, fan 4 on the shared bit
        for (int k = 7; k > 0; k--) begin
            lv <= 8'h01 << k;
            step(3);
            rc(8'h41, 8'h80);
            al(1'b1);
            lv <= 8'h00;
            step(3);
            rc(8'h42, k == 1 ? 8'h00 : 8'h01 << k);
            rc(8'h42, 8'h00);
        end
        // thermal timer and general input on the shared bit
        for (int m = 1; m < 4; m += 2) begin
            p14 <= m[1:0];
            tmr <= 1'b1;
            gpio <= 1'b1;
            step(5);
            rc(8'h42, 8'h20);
            tmr <= 1'b0;
            gpio <= 1'b0;
            step(5);
            host.rd(8'h42, got);
            rc(8'h42, 8'h00);
        end
        p14 <= 2'h0;
        $display("test faults done");
        // alert service: read, mask, poll, unmask
        on10 <= 1'b1;
        lv <= 8'h80;
        step(4);
        al(1'b0);
        rc(8'h42, 8'h80);
        host.wr(8'h75, 8'h80);
        step(3);
        al(1'b1);
        lv <= 8'h00;
        rc(8'h42, 8'h80);
        rc(8'h42, 8'h00);
        host.wr(8'h75, 8'h00);
        host.wr(8'h74, 8'h80);
        lv <= 8'h04;
        step(4);
        al(1'b1);
        host.wr(8'h74, 8'h00);
        step(4);
        al(1'b0);
        lv <= 8'h00;
        step(6);
        al(1'b0);
        rc(8'h42, 8'h04);
        step(3);
        al(1'b1);
        host.wr(8'h74, 8'h08);
        conv(3, 8'hC1);
        step(3);
        al(1'b1);
        rc(8'h41, 8'h08);
        conv(3, 8'h80);
        rc(8'h41, 8'h08);
        host.wr(8'h74, 8'h00);
        on10 <= 1'b0;
        p14 <= 2'h2;
        lv <= 8'h40;
        step(4);
        chk("pin 14 drive", 8'h01, {7'h0, oe14});
        chk("pin 10 drive", 8'h00, {7'h0, oe10});
        lv <= 8'h00;
        step(5);
        rc(8'h42, 8'h40);
        step(3);
        al(1'b1);
        $display("test alert done");
        // second reset mid-run, pin functions selected, non-zero id code
        host.wr(8'h75, 8'h3C);
        heat_sel <= 1'b1;
        vid_sel <= 1'b1;
        sys_rst <= 1'b1;
        step(2);
        sys_rst <= 1'b0;
        rc(8'h75, 8'h00);
        step(4);
        rc(8'h41, 8'h00);
        rc(8'h42, 8'h00);
        al(1'b1);
        $display("test reset done");
        conclude();
    end
endmodule
`default_nettype wire
